/* core/spdc_pkg.sv */
// Purpose: shared constants and carriers for the sleep power-down controller
// Assumes: one 125 MHz clock, registers over a plain strobe port
// Notes: register offsets are word indices on the plain port
package spdc_pkg;
  localparam int unsigned CLK_MHZ = 125;
  // regulator settle time after low-power sleep, in microseconds
  localparam int unsigned LP_WAKE_US = 10;
  localparam int unsigned LP_WAKE_CYC = LP_WAKE_US * CLK_MHZ;
  localparam int unsigned WAKE_CNT_W = 16;
  localparam int unsigned WDT_W = 18;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NSRC = 8;
  // register indices
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h1;
  localparam logic [3:0] REG_IEN = 4'h2;
  localparam logic [3:0] REG_WDT = 4'h3;
  // control field positions
  localparam int unsigned CTL_LPSEL = 1;
  localparam int unsigned CTL_GIE = 7;
  localparam int unsigned CTL_NOLP = 2;
  localparam int unsigned CTL_CWGHF = 3;
  localparam int unsigned CTL_WDTSLP = 4;
  localparam int unsigned CTL_WDTEN = 5;
  localparam logic [7:0] CTL_RESET = 8'h01;
  // status field positions
  localparam int unsigned ST_TO = 4;
  localparam int unsigned ST_PD = 3;
  localparam int unsigned ST_ASLEEP = 0;
  localparam int unsigned ST_SETTLE = 1;
  localparam logic [15:0] WDT_ONE = 16'h0001;

  typedef enum logic [1:0] {SPDC_RUN, SPDC_SLEEP, SPDC_SETTLE} spdc_state_t;

  typedef struct packed {
    spdc_state_t st;
    logic [7:0] ctrl;
    logic [7:0] ien;
    logic to_flag;
    logic pd_flag;
    logic [WAKE_CNT_W-1:0] wcnt;
    logic [WDT_W-1:0] wdt;
    logic [7:0] rdata;
    logic vector_call;
  } spdc_state_s_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } spdc_bus_t;
endpackage

/* core/spdc_top.sv */
// Purpose: sleep entry, wake-up and regulator control for a small core
// Assumes: inputs synchronous to sys_clk, core gives a one-cycle sleep strobe
// Notes: full-reset sources act through rst_b; watchdog wake continues code
`timescale 1ns/1ps
module spdc_top #(
  parameter int unsigned LP_WAKE_CYCLES = spdc_pkg::LP_WAKE_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // register port
  input wire spdc_pkg::spdc_bus_t bus,
  output logic [spdc_pkg::DATA_W-1:0] rdata,
  // core side
  input wire logic sleep_instr,
  input wire logic clrwdt_instr,
  output logic cpu_clk_en,
  output logic prefetch_hold,
  output logic vector_call,
  // interrupt sources
  input wire logic [spdc_pkg::NSRC-1:0] irq_flags,
  // peripheral clock requests
  input wire logic t1_slow_clk,
  input wire logic adc_rc_sel,
  input wire logic cwg_hf_need,
  output logic low_freq_internal_osc_en,
  output logic high_freq_internal_osc_en,
  output logic timer1_run_en,
  output logic adc_run_en,
  // pins
  input wire logic [7:0] pin_out_in,
  input wire logic [7:0] pin_oe_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  // regulator and watchdog
  output logic regulator_low_power,
  output logic wdt_timeout,
  output logic asleep
);
  localparam int unsigned WAKE_CNT_W = spdc_pkg::WAKE_CNT_W;

  spdc_pkg::spdc_state_s_t s_q, s_d;
  logic [7:0] pout_q, poe_q;
  logic pending;
  logic wdt_run;

  // low-power sleep selected and no incompatible peripheral enabled
  function automatic logic lp_sleep_on(input logic [7:0] c);
    return c[spdc_pkg::CTL_LPSEL] && !c[spdc_pkg::CTL_NOLP];
  endfunction

  // any enabled source pending; global enable not looked at
  assign pending = |(irq_flags & s_q.ien);

  // watchdog runs awake when enabled, and in sleep only if also enabled for sleep
  assign wdt_run = s_q.ctrl[spdc_pkg::CTL_WDTEN] &&
                   (s_q.st == spdc_pkg::SPDC_RUN || s_q.ctrl[spdc_pkg::CTL_WDTSLP]);

  // next-state logic
  always_comb begin
    s_d = s_q;
    s_d.vector_call = 1'b0;
    s_d.rdata = '0;
    if (wdt_run) begin
      s_d.wdt = s_q.wdt + spdc_pkg::WDT_W'(1);
    end
    if (clrwdt_instr) begin
      s_d.wdt = '0;
    end
    if (bus.wr) begin
      unique case (bus.addr)
        spdc_pkg::REG_CTRL: s_d.ctrl = bus.wdata;
        spdc_pkg::REG_IEN: s_d.ien = bus.wdata;
        default: ;
      endcase
    end
    if (bus.rd) begin
      unique case (bus.addr)
        spdc_pkg::REG_CTRL: s_d.rdata = s_q.ctrl;
        spdc_pkg::REG_IEN: s_d.rdata = s_q.ien;
        spdc_pkg::REG_STAT: begin
          s_d.rdata[spdc_pkg::ST_TO] = s_q.to_flag;
          s_d.rdata[spdc_pkg::ST_PD] = s_q.pd_flag;
          s_d.rdata[spdc_pkg::ST_ASLEEP] = s_q.st == spdc_pkg::SPDC_SLEEP;
          s_d.rdata[spdc_pkg::ST_SETTLE] = s_q.st == spdc_pkg::SPDC_SETTLE;
        end
        spdc_pkg::REG_WDT: s_d.rdata = s_q.wdt[spdc_pkg::WDT_W-1 -: 8];
        default: s_d.rdata = '0;
      endcase
    end
    unique case (s_q.st)
      spdc_pkg::SPDC_RUN: begin
        if (sleep_instr && !pending) begin
          s_d.st = spdc_pkg::SPDC_SLEEP;
          s_d.wdt = '0;
          s_d.pd_flag = 1'b0;
          s_d.to_flag = 1'b1;
        end
      end
      spdc_pkg::SPDC_SLEEP: begin
        // late interrupt or watchdog overflow wakes at once
        if (pending || wdt_timeout) begin
          s_d.wdt = '0;
          // low-power wake needs the regulator settle time first
          if (lp_sleep_on(s_q.ctrl)) begin
            s_d.st = spdc_pkg::SPDC_SETTLE;
            s_d.wcnt = WAKE_CNT_W'(LP_WAKE_CYCLES - 1);
          end else begin
            s_d.st = spdc_pkg::SPDC_RUN;
            s_d.vector_call = s_q.ctrl[spdc_pkg::CTL_GIE] && pending;
          end
        end
      end
      spdc_pkg::SPDC_SETTLE: begin
        if (s_q.wcnt == '0) begin
          s_d.st = spdc_pkg::SPDC_RUN;
          s_d.vector_call = s_q.ctrl[spdc_pkg::CTL_GIE] && pending;
        end else begin
          s_d.wcnt = s_q.wcnt - WAKE_CNT_W'(1);
        end
      end
    endcase
  end

  // state register; only rst_b, the full-reset path, restarts it
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q.st <= spdc_pkg::SPDC_RUN;
      s_q.ctrl <= spdc_pkg::CTL_RESET;
      s_q.ien <= '0;
      s_q.to_flag <= 1'b1;
      s_q.pd_flag <= 1'b1;
      s_q.wcnt <= '0;
      s_q.wdt <= '0;
      s_q.rdata <= '0;
      s_q.vector_call <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // pin latch freezes drive while asleep
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pout_q <= '0;
      poe_q <= '0;
    end else if (s_q.st == spdc_pkg::SPDC_RUN && !(sleep_instr && !pending)) begin
      pout_q <= pin_out_in;
      poe_q <= pin_oe_in;
    end
  end

  assign pin_out = pout_q;
  assign pin_oe = poe_q;
  assign rdata = s_q.rdata;
  assign asleep = s_q.st != spdc_pkg::SPDC_RUN;
  assign cpu_clk_en = s_q.st == spdc_pkg::SPDC_RUN;
  assign prefetch_hold = s_q.st != spdc_pkg::SPDC_RUN;
  assign vector_call = s_q.vector_call;
  assign wdt_timeout = &s_q.wdt;
  assign low_freq_internal_osc_en = 1'b1;
  assign timer1_run_en = cpu_clk_en || t1_slow_clk;
  assign adc_run_en = cpu_clk_en || adc_rc_sel;
  assign high_freq_internal_osc_en = cpu_clk_en ||
                                     (s_q.ctrl[spdc_pkg::CTL_CWGHF] && cwg_hf_need);
  // low regulator only in sleep, select set, nothing blocking
  assign regulator_low_power = s_q.st == spdc_pkg::SPDC_SLEEP &&
                               lp_sleep_on(s_q.ctrl);

  // entry clears the power-down flag and sets the time-out flag
  a_entry_flags: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_q.st == spdc_pkg::SPDC_RUN && sleep_instr && !pending |=>
      !s_q.pd_flag && s_q.to_flag && s_q.wdt == '0) else $error("entry flags wrong");
  a_entry_to: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(asleep) |-> s_q.to_flag) else $error("timeout flag not set");
  a_nop_sleep: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_q.st == spdc_pkg::SPDC_RUN && sleep_instr && pending |=>
      !asleep && $stable(s_q.pd_flag)) else $error("sleep not a no-op");
  a_only_instr: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(asleep) |-> $past(sleep_instr)) else $error("sleep without instruction");
  a_clk_gate: assert property (@(posedge sys_clk) disable iff (!rst_b)
    asleep |-> !cpu_clk_en) else $error("cpu clock on in sleep");
  a_pin_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_q.st == spdc_pkg::SPDC_SLEEP && $past(s_q.st) == spdc_pkg::SPDC_SLEEP |->
      $stable(pin_out) && $stable(pin_oe)) else $error("pins moved in sleep");
  a_late_wake: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_q.st == spdc_pkg::SPDC_SLEEP && pending |=>
      s_q.st != spdc_pkg::SPDC_SLEEP && s_q.wdt == '0) else $error("late irq no wake");
  a_reg_low: assert property (@(posedge sys_clk) disable iff (!rst_b)
    regulator_low_power |-> asleep && !s_q.ctrl[spdc_pkg::CTL_NOLP])
    else $error("regulator low wrongly");
  a_settle_len: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(s_q.st == spdc_pkg::SPDC_SETTLE) |-> !cpu_clk_en [*2])
    else $error("settle too short");
  a_lf_osc: assert property (@(posedge sys_clk) disable iff (!rst_b)
    asleep |-> low_freq_internal_osc_en) else $error("slow oscillator off");

  // entry clears the watchdog
  a_wdt_entry_clr: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_q.st == spdc_pkg::SPDC_RUN && sleep_instr && !pending |=> s_q.wdt == '0)
    else $error("watchdog not cleared on entry");
  // watchdog keeps counting in sleep when enabled for it
  a_wdt_sleep_run: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_q.st == spdc_pkg::SPDC_SLEEP && wdt_run && !pending && !wdt_timeout &&
      !clrwdt_instr |=> s_q.wdt == $past(s_q.wdt) + spdc_pkg::WDT_W'(1))
    else $error("watchdog stalled in sleep");
  // any wake-up leaves the watchdog cleared
  a_wake_wdt_clr: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $fell(s_q.st == spdc_pkg::SPDC_SLEEP) |-> s_q.wdt == '0)
    else $error("watchdog not cleared on wake");
  // no enabled source and no time-out keeps the device asleep
  a_no_wake_off: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_q.st == spdc_pkg::SPDC_SLEEP && !pending && !wdt_timeout |=>
      s_q.st == spdc_pkg::SPDC_SLEEP)
    else $error("woke without enabled source");
  // watchdog overflow wakes and continues
  a_wdt_wake: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_q.st == spdc_pkg::SPDC_SLEEP && wdt_timeout |=> s_q.st != spdc_pkg::SPDC_SLEEP)
    else $error("watchdog did not wake");
  // vector only when global enable was set and a source pended
  a_vector_cause: assert property (@(posedge sys_clk) disable iff (!rst_b)
    vector_call |-> $past(s_q.ctrl[spdc_pkg::CTL_GIE]) && $past(pending))
    else $error("vector without cause");
  // a normal wake with global enable set and source pending vectors
  a_vector_gie: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_q.st == spdc_pkg::SPDC_SLEEP && pending && s_q.ctrl[spdc_pkg::CTL_GIE] &&
      !lp_sleep_on(s_q.ctrl) |=> vector_call)
    else $error("vector missing");
  // prefetched instruction held while the core is stopped
  a_prefetch_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
    asleep |-> prefetch_hold) else $error("prefetch not held");
  // timer1 keeps running on a slow clock
  a_timer1_run: assert property (@(posedge sys_clk) disable iff (!rst_b)
    t1_slow_clk |-> timer1_run_en) else $error("timer1 stopped");
  // adc keeps running on its own rc clock
  a_adc_run: assert property (@(posedge sys_clk) disable iff (!rst_b)
    adc_rc_sel |-> adc_run_en) else $error("adc stopped");
  // waveform unit may keep the fast oscillator alive
  a_hf_osc: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_q.ctrl[spdc_pkg::CTL_CWGHF] && cwg_hf_need |-> high_freq_internal_osc_en)
    else $error("fast oscillator dropped");
  // low regulator whenever selected, nothing blocking, and in the sleep state
  a_reg_low_sel: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_q.st == spdc_pkg::SPDC_SLEEP && lp_sleep_on(s_q.ctrl) |-> regulator_low_power)
    else $error("regulator not low in sleep");
  // regulator normal while the core runs
  a_reg_awake: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cpu_clk_en |-> !regulator_low_power) else $error("regulator low while awake");
  // settle ends when its counter runs out
  a_settle_end: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_q.st == spdc_pkg::SPDC_SETTLE && s_q.wcnt == '0 |=> s_q.st == spdc_pkg::SPDC_RUN)
    else $error("settle did not end");
  // normal sleep resumes with no settle delay
  a_normal_fast: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_q.st == spdc_pkg::SPDC_SLEEP && (pending || wdt_timeout) &&
      !lp_sleep_on(s_q.ctrl) |=> s_q.st == spdc_pkg::SPDC_RUN)
    else $error("normal wake delayed");
  // awake, the pins follow the core one cycle later
  a_pin_follow: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_q.st == spdc_pkg::SPDC_RUN && !sleep_instr |=>
      pin_out == $past(pin_out_in) && pin_oe == $past(pin_oe_in))
    else $error("pins not following core");
endmodule

/* bench/tb.sv */
// Purpose: self-checking bench for the sleep power-down controller
// Assumes: settle count shortened to 4 cycles, watchdog clear strobe low except in the watchdog test
// Notes: inputs change by non-blocking assignment on the rising edge
`timescale 1ns/1ps
module tb;
  logic sys_clk, rst_b, sleep_instr, clrwdt_instr, t1_slow_clk, adc_rc_sel, cwg_hf_need;
  spdc_pkg::spdc_bus_t bus;
  logic [7:0] irq_flags, pin_out_in, pin_oe_in, rdata, pin_out, pin_oe;
  logic cpu_clk_en, prefetch_hold, vector_call, lfo_en, hfo_en, t1_en, adc_en;
  logic reg_lp, wdt_to, asleep;
  int fails, num_checks, n;
  spdc_top #(.LP_WAKE_CYCLES(4)) spdc_top_inst (.sys_clk(sys_clk), .rst_b(rst_b), .bus(bus),
    .rdata(rdata), .sleep_instr(sleep_instr), .clrwdt_instr(clrwdt_instr),
    .cpu_clk_en(cpu_clk_en), .prefetch_hold(prefetch_hold), .vector_call(vector_call),
    .irq_flags(irq_flags), .t1_slow_clk(t1_slow_clk), .adc_rc_sel(adc_rc_sel),
    .cwg_hf_need(cwg_hf_need), .low_freq_internal_osc_en(lfo_en),
    .high_freq_internal_osc_en(hfo_en), .timer1_run_en(t1_en), .adc_run_en(adc_en),
    .pin_out_in(pin_out_in), .pin_oe_in(pin_oe_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .regulator_low_power(reg_lp), .wdt_timeout(wdt_to), .asleep(asleep));
  // clock at 125 MHz
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // compare one value and count it
  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one-cycle register write
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk) begin
      bus.addr <= a; bus.wdata <= d; bus.wr <= 1'b1;
    end
    @(posedge sys_clk) bus.wr <= 1'b0;
  endtask
  // one-cycle register read, data checked in the following cycle
  task rd(input string what, input logic [3:0] a, input logic [7:0] exp);
    @(posedge sys_clk) begin
      bus.addr <= a; bus.rd <= 1'b1;
    end
    @(posedge sys_clk) bus.rd <= 1'b0;
    #1 chk(what, exp, rdata);
  endtask
  task step;
    @(posedge sys_clk);
    #1;
  endtask
  // sleep strobe; returns just after the cycle where asleep should show
  task go_sleep;
    @(posedge sys_clk) sleep_instr <= 1'b1;
    @(posedge sys_clk) sleep_instr <= 1'b0;
    #1;
  endtask
  // change pending flags; returns just after the edge that samples them
  task raise(input logic [7:0] f);
    @(posedge sys_clk) irq_flags <= f;
    step;
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // hang guard, well beyond the expected run
  initial begin
    #100000;
    fails++;
    end_sim;
  end
  // main sequence
  initial begin
    rst_b = 1'b0; bus = '0; sleep_instr = 1'b0; clrwdt_instr = 1'b0; irq_flags = 8'h00;
    t1_slow_clk = 1'b0; adc_rc_sel = 1'b0; cwg_hf_need = 1'b0;
    pin_out_in = 8'hA5; pin_oe_in = 8'h3C;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd("ctrl", 4'h0, 8'h01);
    rd("status", 4'h1, 8'h18);
    rd("ien", 4'h2, 8'h00);
    rd("unmapped", 4'hF, 8'h00);
    $display("test reset done");
    // enabled flag pending before sleep: no-op
    wr(4'h2, 8'h01);
    irq_flags <= 8'h01;
    go_sleep;
    chk("noop asleep", 8'h00, {7'h00, asleep});
    rd("noop status", 4'h1, 8'h18);
    $display("test pending before sleep done");
    // normal sleep, pins frozen, disabled source ignored
    wr(4'h0, 8'h09);
    irq_flags <= 8'h00; t1_slow_clk <= 1'b1; cwg_hf_need <= 1'b1;
    go_sleep;
    chk("asleep", 8'h01, {7'h00, asleep});
    chk("cpu clk", 8'h00, {7'h00, cpu_clk_en});
    chk("prefetch", 8'h01, {7'h00, prefetch_hold});
    chk("lfo", 8'h01, {7'h00, lfo_en});
    chk("timer1", 8'h01, {7'h00, t1_en});
    chk("adc", 8'h00, {7'h00, adc_en});
    chk("hfo", 8'h01, {7'h00, hfo_en});
    chk("reg lp", 8'h00, {7'h00, reg_lp});
    @(posedge sys_clk) begin
      pin_out_in <= 8'h5A; pin_oe_in <= 8'hC3;
    end
    step;
    step;
    chk("pin out", 8'hA5, pin_out);
    chk("pin oe", 8'h3C, pin_oe);
    raise(8'h02);
    chk("disabled src", 8'h01, {7'h00, asleep});
    raise(8'h03);
    chk("wake", 8'h00, {7'h00, asleep});
    chk("no vector", 8'h00, {7'h00, vector_call});
    rd("status slept", 4'h1, 8'h10);
    rd("wdt cleared", 4'h3, 8'h00);
    $display("test normal sleep done");
    // global enable set: vector after wake
    wr(4'h0, 8'h81);
    irq_flags <= 8'h00;
    go_sleep;
    raise(8'h01);
    chk("vector", 8'h01, {7'h00, vector_call});
    chk("wake gie", 8'h00, {7'h00, asleep});
    rd("status gie", 4'h1, 8'h10);
    $display("test vectored wake done");
    // low-power sleep with settle delay
    wr(4'h0, 8'h03);
    irq_flags <= 8'h00;
    go_sleep;
    chk("reg lp on", 8'h01, {7'h00, reg_lp});
    raise(8'h01);
    chk("settling", 8'h00, {7'h00, cpu_clk_en});
    n = 0;
    while (cpu_clk_en !== 1'b1 && n < 20) begin
      step;
      n++;
    end
    chk("settle len", 8'h04, 8'(n));
    // incompatible peripheral keeps regulator normal
    wr(4'h0, 8'h07);
    irq_flags <= 8'h00;
    go_sleep;
    chk("reg lp held", 8'h00, {7'h00, reg_lp});
    raise(8'h01);
    n = 0;
    while (cpu_clk_en !== 1'b1 && n < 20) begin
      step;
      n++;
    end
    chk("woken", 8'h00, {7'h00, asleep});
    $display("test low-power sleep done");
    // watchdog: cleared on entry, runs in sleep, cleared on wake and by strobe
    wr(4'h0, 8'h31);
    irq_flags <= 8'h00; adc_rc_sel <= 1'b1;
    repeat (1100) @(posedge sys_clk);
    rd("wdt awake", 4'h3, 8'h01);
    chk("wdt to", 8'h00, {7'h00, wdt_to});
    go_sleep;
    rd("wdt entry", 4'h3, 8'h00);
    chk("adc sleep", 8'h01, {7'h00, adc_en});
    repeat (1100) @(posedge sys_clk);
    rd("wdt in sleep", 4'h3, 8'h01);
    raise(8'h01);
    rd("wdt wake", 4'h3, 8'h00);
    repeat (1100) @(posedge sys_clk);
    @(posedge sys_clk) clrwdt_instr <= 1'b1;
    @(posedge sys_clk) clrwdt_instr <= 1'b0;
    rd("wdt clear", 4'h3, 8'h00);
    $display("test watchdog done");
    end_sim;
  end
endmodule
